//--- dv/sapc_asserts.sv
/*
  Checker for sapc_top: pin direction, idle levels and read data timing.
  Bound from tb_top; sees only top ports in the clk_i domain.
*/
module sapc_chk (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic stop_i,
  input wire sapc_pkg::sapc_req_t req_i,
  input wire logic [sapc_pkg::DATA_W-1:0] rdata_o,
  input wire sapc_pkg::sapc_pin_t tx_bit_clock_o,
  input wire sapc_pkg::sapc_pin_t tx_word_select_o,
  input wire logic tx_data_out_a_o,
  input wire logic tx_data_out_b_o,
  input wire logic tx_data_out_c_o,
  input wire sapc_pkg::sapc_pin_t rx_bit_clock_o,
  input wire sapc_pkg::sapc_pin_t rx_word_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_stop_txck: assert property ((stop_i && ce_i)[*2] |-> !tx_bit_clock_o.oe)
    else $error("tx bit clock driven in stop");
  chk_stop_txws: assert property ((stop_i && ce_i)[*2] |-> !tx_word_select_o.oe)
    else $error("tx word select driven in stop");
  chk_stop_rx: assert property ((stop_i && ce_i)[*2] |-> !rx_bit_clock_o.oe &&
    !rx_word_select_o.oe)
    else $error("rx pins driven in stop");
  chk_stop_sdo: assert property ((stop_i && ce_i)[*2] |->
    tx_data_out_a_o && tx_data_out_b_o && tx_data_out_c_o)
    else $error("tx data not high in stop");
  chk_tx_dir: assert property (tx_bit_clock_o.oe == tx_word_select_o.oe)
    else $error("tx clock and word select differ in direction");
  chk_rx_dir: assert property (rx_bit_clock_o.oe == rx_word_select_o.oe)
    else $error("rx clock and word select differ in direction");
  chk_ws_edge: assert property (tx_word_select_o.oe && $past(tx_word_select_o.oe) &&
    $changed(tx_word_select_o.o) |-> $fell(tx_bit_clock_o.o))
    else $error("tx word select moved off a falling bit clock");
  chk_rd_only: assert property (rdata_o != '0 |-> $past(req_i.rd))
    else $error("read data outside read slot");
  chk_soft_rst: assert property (req_i.wr && ce_i &&
    req_i.addr == sapc_pkg::OFF_CTRL && req_i.wdata[sapc_pkg::CTRL_SRST] ##1 ce_i
    |=> !tx_bit_clock_o.oe && !tx_word_select_o.oe && tx_data_out_a_o)
    else $error("soft reset left tx pins active");
endmodule

//--- dv/sapc_codec.sv
/*
  Far-side audio converter model: bit clock, word select and serial data.
  Clock and word select run only while en_i is high.
*/
module sapc_codec #(
  parameter int HALF = 16
) (
  input wire logic en_i,
  input wire logic [23:0] word_i,
  output logic sck_o,
  output logic ws_o,
  output logic sd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    sck_o = 1'b0;
    ws_o = 1'b0;
    sd_o = 1'b0;
    cnt = 0;
    #3;
    forever begin
      #HALF;
      if (!en_i) begin
        // idle line keeps moving so a stale level is never trusted
        sd_o = ~sd_o;
      end else begin
        sck_o = ~sck_o;
        if (!sck_o) begin
          cnt = (cnt == 23) ? 0 : cnt + 1;
          if (cnt == 0) ws_o = ~ws_o;
          sd_o = word_i[23-cnt];
        end
      end
    end
  end
endmodule

//--- dv/tb_top.sv
/*
  Self-checking bench for sapc_top: register port, pin direction, idle
  levels, tx words as master and slave, rx capture as slave.
  Assumes sapc_pkg, sapc_top, sapc_codec and sapc_chk are compiled first.
*/
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t %h vs %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, ce_i, stop_i, pend, rx_b, t_en, r_en;
  sapc_pkg::sapc_req_t req_i;
  logic [31:0] rdata_o;
  sapc_pkg::sapc_pin_t tck, tws, rck, rws;
  logic sdo_a, sdo_b, sdo_c, pt_ck, pt_ws, pr_ck, pr_ws, pr_sd;
  logic [23:0] word, got;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  int fail_count, comparisons, i;
  wire tck_w = tck.oe ? tck.o : pt_ck;
  wire tws_w = tws.oe ? tws.o : pt_ws;
  wire rck_w = rck.oe ? rck.o : pr_ck;
  wire rws_w = rws.oe ? rws.o : pr_ws;

  sapc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .stop_i(stop_i),
    .req_i(req_i), .rdata_o(rdata_o), .tx_bit_clock_i(tck_w), .tx_word_select_i(tws_w),
    .tx_bit_clock_o(tck), .tx_word_select_o(tws), .tx_data_out_a_o(sdo_a),
    .tx_data_out_b_o(sdo_b), .tx_data_out_c_o(sdo_c), .rx_link_clk_i(rck_w),
    .rx_word_select_i(rws_w), .rx_data_in_a_i(pr_sd), .rx_data_in_b_i(rx_b),
    .rx_bit_clock_o(rck), .rx_word_select_o(rws));
  // slow tx slave clock leaves room for the synchroniser lag
  sapc_codec #(.HALF(40)) ptx (.en_i(t_en), .word_i(24'h000000), .sck_o(pt_ck),
    .ws_o(pt_ws), .sd_o());
  sapc_codec #(.HALF(16)) prx (.en_i(r_en), .word_i(24'hffffff), .sck_o(pr_ck),
    .ws_o(pr_ws), .sd_o(pr_sd));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) rx_b <= 1'($urandom);
  always @(posedge clk_i) begin
    if (pend) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_o, exp_v)
    end
    pend = req_i.rd;
  end
  initial begin
    #100us;
    fail_count++;
    test_done();
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
    req_i.rd <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // skips the first boundary: the word before it may still be zeros
  task automatic grab();
    @(tws_w);
    @(tws_w);
    for (i = 0; i < 24; i++) begin
      @(posedge tck_w);
      got = {got[22:0], sdo_a};
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(41));
    {rst_b_i, stop_i, pend, rx_b, t_en} = 5'h00;
    {ce_i, r_en} = 2'h3;
    req_i = '0;
    idle(10);
    rst_b_i <= 1'b1;
    r_en <= 1'b0;
    idle(2);
    `CHK({tck.oe, tws.oe, rck.oe, rws.oe}, 4'h0)
    `CHK({sdo_a, sdo_b, sdo_c}, 3'h7)
    bus(1'b0, sapc_pkg::OFF_CTRL, 32'h0);
    bus(1'b0, sapc_pkg::OFF_CLKDIV, 32'h3);
    bus(1'b0, 8'h20, 32'h0);
    word = 24'($urandom);
    bus(1'b1, sapc_pkg::OFF_TXA, {8'h00, word});
    bus(1'b0, sapc_pkg::OFF_TXA, {8'h00, word});
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'h48);
    idle(3);
    `CHK({tck.oe, tws.oe, rck.oe}, 3'h6)
    grab();
    `CHK(got, word)
    `CHK({sdo_b, sdo_c}, 2'h3)
    stop_i <= 1'b1;
    idle(3);
    `CHK({tck.oe, tws.oe, sdo_a}, 3'h1)
    stop_i <= 1'b0;
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'hc8);
    idle(2);
    `CHK({tck.oe, tws.oe, sdo_a}, 3'h1)
    bus(1'b0, sapc_pkg::OFF_CTRL, 32'hc8);
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'h40);
    idle(2);
    `CHK({tck.oe, tws.oe}, 2'h0)
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'h08);
    t_en <= 1'b1;
    idle(2);
    `CHK(tck.oe, 1'b0)
    grab();
    `CHK(got, word)
    t_en <= 1'b0;
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'h01);
    r_en <= 1'b1;
    idle(1000);
    `CHK({rck.oe, rws.oe}, 2'h0)
    bus(1'b0, sapc_pkg::OFF_RXA, 32'hffffff);
    bus(1'b0, sapc_pkg::OFF_RXB, 32'h0);
    r_en <= 1'b0;
    bus(1'b1, sapc_pkg::OFF_CTRL, 32'h05);
    idle(3);
    `CHK({rck.oe, rws.oe}, 2'h3)
    stop_i <= 1'b1;
    idle(3);
    `CHK({rck.oe, rws.oe}, 2'h0)
    stop_i <= 1'b0;
    idle(2);
    test_done();
  end
endmodule

bind sapc_top sapc_chk u_chk (.clk_i, .rst_b_i, .ce_i, .stop_i, .req_i, .rdata_o,
  .tx_bit_clock_o, .tx_word_select_o, .tx_data_out_a_o, .tx_data_out_b_o,
  .tx_data_out_c_o, .rx_bit_clock_o, .rx_word_select_o);

//--- hw/sapc_pkg.sv
/*
  Shared constants and carrier types for the serial audio pin control block:
  register offsets, control field positions, reset values and pin bundles.
  Assumes a 200 MHz system clock and a plain single-cycle register port.
*/
package sapc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned CNT_W = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLKDIV = 8'h04;
  localparam logic [7:0] OFF_TXA = 8'h08;
  localparam logic [7:0] OFF_TXB = 8'h0c;
  localparam logic [7:0] OFF_TXC = 8'h10;
  localparam logic [7:0] OFF_RXA = 8'h14;
  localparam logic [7:0] OFF_RXB = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;

  // control field positions
  localparam int unsigned CTRL_RXA_EN = 0;
  localparam int unsigned CTRL_RXB_EN = 1;
  localparam int unsigned CTRL_RX_MST = 2;
  localparam int unsigned CTRL_TX_EN = 3;
  localparam int unsigned CTRL_TX_MST = 6;
  localparam int unsigned CTRL_SRST = 7;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned N_TX = 3;
  localparam int unsigned N_RX = 2;

  // status field positions
  localparam int unsigned STAT_TX_WS = 0;
  localparam int unsigned STAT_RX_WS = 1;
  localparam int unsigned STAT_RXCNT = 8;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CLKDIV_RST = 8'h03;

  typedef struct packed {
    logic o;
    logic oe;
  } sapc_pin_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sapc_req_t;

  typedef enum logic [0:0] {
    SAPC_IDLE = 1'b0,
    SAPC_RUN = 1'b1
  } sapc_run_t;

endpackage

//--- hw/sapc_ser.sv
/*
  Parameterised shift register, msb first, with parallel load.
  Assumes load and shift come from logic on the same clock; load wins.
*/
module sapc_ser #(
  parameter int unsigned W = 24
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_data_i,
  input wire logic shift_i,
  input wire logic ser_i,
  output logic [W-1:0] par_o,
  output logic msb_o
);

  typedef struct packed {
    logic [W-1:0] sh;
  } sapc_ser_t;

  sapc_ser_t s_q;
  sapc_ser_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.sh = load_data_i;
    end else if (shift_i) begin
      s_d.sh = {s_q.sh[W-2:0], ser_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign par_o = s_q.sh;
  assign msb_o = s_q.sh[W-1];

endmodule

//--- hw/sapc_top.sv
/*
  Serial audio pin control: register port, bit clock and word-select
  generation, three transmit shifters, two receive shifters on the receive
  bit clock, and the direction and idle level of every audio pin.
  Assumes pin wires are resolved outside from o/oe pairs and that
  rx_link_clk_i carries the resolved receive bit clock wire.
*/
// Implementation choices: the strobed register port and the register addresses.
// Operation
// - receive word select is an output as master, an input as slave.
// - receive word select marks word alignment and left or right channel.
// - receive word select floats when receivers off, in any reset, in stop.
// - each transmit data output sits high when its transmitter is off or held.
// - transmit bit clock is driven as master, taken as input as slave.
// - transmit bit clock floats when transmitters off, in any reset, in stop.
// - transmit word select is an output as master, an input as slave.
// - transmit word select delimits words and marks left or right channel.
// - transmit word select floats when transmitters off, in reset, in stop.
// - a floating clock or word-select pin never reaches internal logic.
// - each receive data input is ignored while its receiver is off or held.
// - receive bit clock is output as master, input as slave, floats when off.
module sapc_top #(
  parameter int unsigned WORD_W = sapc_pkg::WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic stop_i,
  input wire sapc_pkg::sapc_req_t req_i,
  output logic [sapc_pkg::DATA_W-1:0] rdata_o,
  input wire logic tx_bit_clock_i,
  input wire logic tx_word_select_i,
  output sapc_pkg::sapc_pin_t tx_bit_clock_o,
  output sapc_pkg::sapc_pin_t tx_word_select_o,
  output logic tx_data_out_a_o,
  output logic tx_data_out_b_o,
  output logic tx_data_out_c_o,
  input wire logic rx_link_clk_i,
  input wire logic rx_word_select_i,
  input wire logic rx_data_in_a_i,
  input wire logic rx_data_in_b_i,
  output sapc_pkg::sapc_pin_t rx_bit_clock_o,
  output sapc_pkg::sapc_pin_t rx_word_select_o
);

  localparam int unsigned BW = $clog2(WORD_W);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);
  localparam int unsigned NTX = sapc_pkg::N_TX;
  localparam int unsigned NRX = sapc_pkg::N_RX;

  typedef struct packed {
    logic [sapc_pkg::CTRL_W-1:0] ctrl;
    logic [sapc_pkg::DIV_W-1:0] div;
    logic [NTX-1:0][WORD_W-1:0] txh;
    logic [NRX-1:0][WORD_W-1:0] rxw;
    sapc_pkg::sapc_run_t st;
    logic [sapc_pkg::DIV_W-1:0] div_cnt;
    logic bck;
    logic ws;
    logic [BW-1:0] bitcnt;
    logic [1:0] tck_sync;
    logic [1:0] tws_sync;
    logic tck_last;
    logic tws_last;
    logic [2:0] rtog;
    logic [1:0] rlr;
    logic [sapc_pkg::CNT_W-1:0] rxcnt;
    logic [sapc_pkg::DATA_W-1:0] rdata;
    sapc_pkg::sapc_pin_t txck;
    sapc_pkg::sapc_pin_t txws;
    sapc_pkg::sapc_pin_t rxck;
    sapc_pkg::sapc_pin_t rxws;
    logic [NTX-1:0] sdo;
  } sapc_state_t;

  typedef struct packed {
    logic [NRX:0] g1;
    logic [NRX:0] g2;
    logic ws_last;
    logic tog;
    logic lr;
    logic [NRX-1:0][WORD_W-1:0] hold;
  } sapc_link_t;

  sapc_state_t s_q;
  sapc_state_t s_d;
  sapc_link_t l_q;
  sapc_link_t l_d;

  logic tx_master;
  logic rx_master;
  logic held;
  logic tx_on;
  logic rx_on;
  logic gen_on;
  logic [NTX-1:0] tx_en;
  logic [NRX-1:0] rx_en;
  logic tx_fall;
  logic tx_load;
  logic tx_shift;
  logic tck_gated;
  logic tws_gated;
  logic [NTX-1:0] tx_msb;
  logic [NRX-1:0][WORD_W-1:0] rx_par;
  logic [NRX-1:0] rx_bit;
  logic link_run;

  // configuration decode
  always_comb begin
    tx_master = s_q.ctrl[sapc_pkg::CTRL_TX_MST];
    rx_master = s_q.ctrl[sapc_pkg::CTRL_RX_MST];
    tx_en = s_q.ctrl[sapc_pkg::CTRL_TX_EN +: NTX];
    rx_en = {s_q.ctrl[sapc_pkg::CTRL_RXB_EN], s_q.ctrl[sapc_pkg::CTRL_RXA_EN]};
    held = s_q.ctrl[sapc_pkg::CTRL_SRST] | stop_i;
    tx_on = ~held & (|tx_en);
    rx_on = ~held & (|rx_en);
    gen_on = (tx_on & tx_master) | (rx_on & rx_master);
  end

  // slave pins only reach logic while the pin is a live input
  assign tck_gated = s_q.tck_sync[1] & tx_on & ~tx_master;
  assign tws_gated = s_q.tws_sync[1] & tx_on & ~tx_master;

  // transmit bit events: own falling edge as master, pin edge as slave
  always_comb begin
    if (tx_master) begin
      tx_fall = (s_q.st == sapc_pkg::SAPC_RUN) & (s_q.div_cnt == s_q.div) & s_q.bck;
      tx_load = tx_fall & (s_q.bitcnt == LAST_BIT);
    end else begin
      tx_fall = tx_on & s_q.tck_last & ~tck_gated;
      tx_load = tx_fall & (tws_gated != s_q.tws_last);
    end
    tx_shift = tx_fall & ~tx_load;
  end

  // one shifter per data output, msb first
  for (genvar i = 0; i < NTX; i++) begin : g_tx
    sapc_ser #(
      .W(WORD_W)
    ) u_tx (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .load_i(tx_load & tx_en[i]),
      .load_data_i(s_q.txh[i]),
      .shift_i(tx_shift),
      .ser_i(1'b0),
      .par_o(),
      .msb_o(tx_msb[i])
    );
  end

  always_comb begin
    s_d = s_q;
    // pin synchronisers: first stage feeds only the second
    s_d.tck_sync = {s_q.tck_sync[0], tx_bit_clock_i};
    s_d.tws_sync = {s_q.tws_sync[0], tx_word_select_i};
    s_d.tck_last = tck_gated;
    if (tx_fall) begin
      s_d.tws_last = tws_gated;
    end
    if (!tx_on) begin
      s_d.tws_last = 1'b0;
    end
    // receive word hand-over: toggle crossing, words held a whole word long
    s_d.rtog = {s_q.rtog[1:0], l_q.tog};
    s_d.rlr = {s_q.rlr[0], l_q.lr};
    // toggle flushes to zero while idle; events seen while off are dropped
    if ((s_q.rtog[2] != s_q.rtog[1]) && rx_on) begin
      s_d.rxw = l_q.hold;
      s_d.rxcnt = s_q.rxcnt + 1'b1;
    end
    // clock and word-select generator
    case (s_q.st)
      sapc_pkg::SAPC_IDLE: begin
        s_d.div_cnt = '0;
        s_d.bck = 1'b0;
        s_d.ws = 1'b0;
        s_d.bitcnt = LAST_BIT; // first falling edge loads a word
        if (gen_on) begin
          s_d.st = sapc_pkg::SAPC_RUN;
        end
      end
      sapc_pkg::SAPC_RUN: begin
        if (!gen_on) begin
          s_d.st = sapc_pkg::SAPC_IDLE;
        end else if (s_q.div_cnt == s_q.div) begin
          s_d.div_cnt = '0;
          s_d.bck = ~s_q.bck;
          if (s_q.bck) begin
            if (s_q.bitcnt == LAST_BIT) begin
              s_d.bitcnt = '0;
              s_d.ws = ~s_q.ws;
            end else begin
              s_d.bitcnt = s_q.bitcnt + 1'b1;
            end
          end
        end else begin
          s_d.div_cnt = s_q.div_cnt + 1'b1;
        end
      end
      default: begin
        s_d.st = sapc_pkg::SAPC_IDLE;
      end
    endcase
    // pin drivers; reset and stop force the idle direction and level
    s_d.txck.oe = tx_on & tx_master;
    s_d.txck.o = s_q.bck & tx_on & tx_master;
    s_d.txws.oe = tx_on & tx_master;
    s_d.txws.o = s_q.ws & tx_on & tx_master;
    s_d.rxck.oe = rx_on & rx_master;
    s_d.rxck.o = s_q.bck & rx_on & rx_master;
    s_d.rxws.oe = rx_on & rx_master;
    s_d.rxws.o = s_q.ws & rx_on & rx_master;
    for (int i = 0; i < NTX; i++) begin
      s_d.sdo[i] = (tx_on & tx_en[i]) ? tx_msb[i] : 1'b1;
    end
    // register port
    s_d.rdata = '0;
    if (req_i.wr) begin
      case (req_i.addr)
        sapc_pkg::OFF_CTRL: s_d.ctrl = req_i.wdata[sapc_pkg::CTRL_W-1:0];
        sapc_pkg::OFF_CLKDIV: s_d.div = req_i.wdata[sapc_pkg::DIV_W-1:0];
        sapc_pkg::OFF_TXA: s_d.txh[0] = req_i.wdata[WORD_W-1:0];
        sapc_pkg::OFF_TXB: s_d.txh[1] = req_i.wdata[WORD_W-1:0];
        sapc_pkg::OFF_TXC: s_d.txh[2] = req_i.wdata[WORD_W-1:0];
        default: begin
        end
      endcase
    end
    if (req_i.rd) begin
      case (req_i.addr)
        sapc_pkg::OFF_CTRL: s_d.rdata[sapc_pkg::CTRL_W-1:0] = s_q.ctrl;
        sapc_pkg::OFF_CLKDIV: s_d.rdata[sapc_pkg::DIV_W-1:0] = s_q.div;
        sapc_pkg::OFF_TXA: s_d.rdata[WORD_W-1:0] = s_q.txh[0];
        sapc_pkg::OFF_TXB: s_d.rdata[WORD_W-1:0] = s_q.txh[1];
        sapc_pkg::OFF_TXC: s_d.rdata[WORD_W-1:0] = s_q.txh[2];
        sapc_pkg::OFF_RXA: s_d.rdata[WORD_W-1:0] = s_q.rxw[0];
        sapc_pkg::OFF_RXB: s_d.rdata[WORD_W-1:0] = s_q.rxw[1];
        sapc_pkg::OFF_STATUS: begin
          s_d.rdata[sapc_pkg::STAT_TX_WS] = tx_master ? s_q.ws : tws_gated;
          s_d.rdata[sapc_pkg::STAT_RX_WS] = s_q.rlr[1];
          s_d.rdata[sapc_pkg::STAT_RXCNT +: sapc_pkg::CNT_W] = s_q.rxcnt;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.ctrl <= sapc_pkg::CTRL_RST;
      s_q.div <= sapc_pkg::CLKDIV_RST;
      s_q.st <= sapc_pkg::SAPC_IDLE;
      s_q.sdo <= '1;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // receive side, clocked by the receive bit clock wire
  // gate levels cross by two flops; the link holds its logic idle while off
  assign link_run = l_q.g2[NRX];

  for (genvar j = 0; j < NRX; j++) begin : g_rx
    assign rx_bit[j] = j == 0 ? rx_data_in_a_i & l_q.g2[j] : rx_data_in_b_i & l_q.g2[j];
    sapc_ser #(
      .W(WORD_W)
    ) u_rx (
      .clk_i(rx_link_clk_i),
      .rst_b_i(link_run & l_q.g2[j]),
      .ce_i(1'b1),
      .load_i(1'b0),
      .load_data_i('0),
      .shift_i(1'b1),
      .ser_i(rx_bit[j]),
      .par_o(rx_par[j]),
      .msb_o()
    );
  end

  always_comb begin
    l_d = l_q;
    l_d.g1 = {rx_on, rx_en};
    l_d.g2 = l_q.g1;
    // word select change closes a word and names its channel
    if (link_run) begin
      l_d.ws_last = rx_word_select_i;
      if (rx_word_select_i != l_q.ws_last) begin
        l_d.hold = rx_par;
        l_d.tog = ~l_q.tog;
        l_d.lr = l_q.ws_last;
      end
    end else begin
      l_d.ws_last = 1'b0;
    end
  end

  // synchronisers carry no reset; they flush within two link clocks
  always_ff @(posedge rx_link_clk_i) begin
    l_q.g1 <= l_d.g1;
    l_q.g2 <= l_d.g2;
    if (!link_run) begin
      l_q.ws_last <= 1'b0;
      l_q.lr <= 1'b0;
      l_q.tog <= 1'b0;
    end else begin
      l_q.ws_last <= l_d.ws_last;
      l_q.lr <= l_d.lr;
      l_q.tog <= l_d.tog;
    end
    l_q.hold <= l_d.hold;
  end

  assign rdata_o = s_q.rdata;
  assign tx_bit_clock_o = s_q.txck;
  assign tx_word_select_o = s_q.txws;
  assign rx_bit_clock_o = s_q.rxck;
  assign rx_word_select_o = s_q.rxws;
  assign tx_data_out_a_o = s_q.sdo[0];
  assign tx_data_out_b_o = s_q.sdo[1];
  assign tx_data_out_c_o = s_q.sdo[2];

endmodule
